// *** verilog/mcec_pkg.sv ***
// Package of constants for the machine-check error code encoder
package mcec_pkg;

    // Error source classes presented by the reporting logic
    localparam logic [3:0] SRC_UNCLASS   = 4'h0;
    localparam logic [3:0] SRC_UCODE_PAR = 4'h1;
    localparam logic [3:0] SRC_EXTERNAL  = 4'h2;
    localparam logic [3:0] SRC_REDUNDANT = 4'h3;
    localparam logic [3:0] SRC_INTERNAL  = 4'h4;
    localparam logic [3:0] SRC_TLB       = 4'h5;
    localparam logic [3:0] SRC_CACHE     = 4'h6;
    localparam logic [3:0] SRC_BUS       = 4'h7;
    localparam logic [3:0] SRC_TIMER     = 4'h8;

    // Simple and fixed codes
    localparam logic [15:0] CODE_NONE       = 16'h0000;
    localparam logic [15:0] CODE_UNCLASS    = 16'h0001;
    localparam logic [15:0] CODE_UCODE_PAR  = 16'h0002;
    localparam logic [15:0] CODE_EXTERNAL   = 16'h0003;
    localparam logic [15:0] CODE_REDUNDANT  = 16'h0004;
    localparam logic [5:0]  PFX_INTERNAL    = 6'h01;
    localparam logic [11:0] PFX_TLB         = 12'h001;
    localparam logic [7:0]  PFX_CACHE       = 8'h01;
    localparam logic [4:0]  PFX_BUS         = 5'h01;
    localparam logic [15:0] CODE_TIMER      = 16'h0400;

    // Sub-field encodings
    localparam logic [1:0] TK_GENERIC  = 2'h2;
    localparam logic [1:0] HL_GENERIC  = 2'h3;
    localparam logic [3:0] RQ_GEN_ERR  = 4'h0;
    localparam logic [3:0] RQ_GEN_RD   = 4'h1;
    localparam logic [3:0] RQ_GEN_WR   = 4'h2;
    localparam logic [3:0] RQ_DATA_RD  = 4'h3;
    localparam logic [3:0] RQ_DATA_WR  = 4'h4;
    localparam logic [3:0] RQ_IFETCH   = 4'h5;
    localparam logic [3:0] RQ_EVICTION_REQ    = 4'h7;
    localparam logic [3:0] RQ_SNOOP    = 4'h8;
    localparam logic [1:0] AS_RESERVED = 2'h1;
    localparam logic [1:0] AS_OTHER    = 2'h3;

endpackage : mcec_pkg

// *** verilog/mcec_encoder.sv ***
// Machine-check architectural error code encoder and status holder
`timescale 1ns/10ps
`default_nettype none

module mcec_encoder (
    input  wire logic        CLOCK_I,
    input  wire logic        RST_I,
    input  wire logic        ERR_VALID_I,
    input  wire logic [3:0]  ERR_SOURCE_I,
    input  wire logic [1:0]  TRANSACTION_KIND_FIELD_I,
    input  wire logic [1:0]  HIERARCHY_LEVEL_FIELD_I,
    input  wire logic [3:0]  REQUEST_KIND_FIELD_I,
    input  wire logic [1:0]  PARTICIPATION_FIELD_I,
    input  wire logic        TIMED_OUT_I,
    input  wire logic [1:0]  ACCESS_SPACE_FIELD_I,
    input  wire logic [9:0]  INTERNAL_DETAIL_I,
    input  wire logic        STATUS_CLEAR_I,
    input  wire logic        BUS_INIT_SIGNAL_I,
    input  wire logic        OBSERVE_STRAP_I,
    input  wire logic        MACHINE_CHECK_ENABLE_BIT_I,
    output logic [15:0]      BANK_ERROR_STATUS_O,
    output logic             ENTRY_VALID_FLAG_O,
    output logic             MC_EXCEPTION_O
);
    import mcec_pkg::*;

    // Block overview
    // The reporting logic presents one error per cycle on ERR_VALID_I,
    // together with a source class and the sub-fields that belong to it.
    // The encoder builds the 16-bit architectural code in one pass of
    // combinational logic and the status holder captures it on the next
    // rising edge, raising the valid flag at the same time.
    // Software later clears the entry through STATUS_CLEAR_I.
    //
    // Timing summary
    // Cycle 0: report strobe and fields stand at the rising edge.
    // Cycle 1: code and valid flag show the report, and stay until the
    //          next report or a clear.
    // A clear in the same cycle as a report is ignored: the report wins,
    // so an error can never be lost to a late clear from software.
    //
    // Bus-init path
    // The bus-init pin, the observation strap and the enable bit come from
    // outside the core clock, so each passes two flip-flops first.
    // The strap is a power-on choice; it is taken once, just after reset.
    // An exception pulse needs a rising bus-init edge, the strap and the
    // enable bit, and lasts exactly one cycle.
    //
    // Limitations
    // Only the architectural low field is produced; model-specific bits,
    // overflow tracking and the rest of the status word live elsewhere.
    // A second report before software reads the first simply overwrites it.

    // Index of each pin inside the synchroniser vector
    localparam int unsigned PIN_BUS_INIT = 0;
    localparam int unsigned PIN_STRAP    = 1;
    localparam int unsigned PIN_ENABLE   = 2;
    localparam int unsigned PIN_COUNT    = 3;

    // Raw pins gathered so one generate loop can synchronise them all
    wire logic [PIN_COUNT-1:0] pin_raw_w = {MACHINE_CHECK_ENABLE_BIT_I,
                                            OBSERVE_STRAP_I,
                                            BUS_INIT_SIGNAL_I};

    // Synchronised pins; only the second flop of each stage drives this
    wire logic [PIN_COUNT-1:0] pin_sync_q;

    // Power-on strap capture state and bus-init previous value
    logic       strap_seen_q;
    logic       strap_q;
    logic       bus_init_prev_q;

    // Request kind legaliser
    // Codes above snoop are reserved and collapse to generic error.
    // Eviction and snoop only make sense for a cache, so outside a cache
    // code they also collapse to generic error rather than mislead software.
    // Generic read and write pass through untouched: the source uses them
    // when it cannot tell instructions from data.
    // Request kind with cache-only kinds folded away for bus
    function automatic logic [3:0] legal_req(input logic [3:0] req, input logic cache_ok);
        if (req > RQ_SNOOP) begin
            legal_req = RQ_GEN_ERR;
        end else if (!cache_ok && (req == RQ_EVICTION_REQ || req == RQ_SNOOP)) begin
            legal_req = RQ_GEN_ERR;
        end else begin
            legal_req = req;
        end
    endfunction : legal_req

    // Sub-field sanitising
    // A reserved transaction kind becomes generic, and a reserved access
    // space becomes other; this keeps every written code architectural at
    // the price of losing what the source meant by the odd value.
    // Level, participation and time-out have no reserved values.
    // Sub-field sanitising: reserved kind becomes generic, reserved space other
    wire logic [1:0] tk_w  = (TRANSACTION_KIND_FIELD_I == 2'h3) ? TK_GENERIC
                           : TRANSACTION_KIND_FIELD_I;
    wire logic [1:0] hl_w  = HIERARCHY_LEVEL_FIELD_I;
    wire logic [1:0] pp_w  = PARTICIPATION_FIELD_I;
    wire logic       to_w  = TIMED_OUT_I;
    wire logic [1:0] as_w  = (ACCESS_SPACE_FIELD_I == AS_RESERVED) ? AS_OTHER
                           : ACCESS_SPACE_FIELD_I;
    wire logic [3:0] rq_c  = legal_req(REQUEST_KIND_FIELD_I, 1'b1);
    wire logic [3:0] rq_nc = legal_req(REQUEST_KIND_FIELD_I, 1'b0);

    // Code selection
    // Exactly one form is chosen per report, from the source class alone.
    // Source code zero and codes nine and above have no arm of their own,
    // so the default arm gives them all the unclassified code.
    // The selection is purely combinational and is only used when the
    // report strobe is high, so its value in idle cycles does not matter.
    // Encoding chosen by the error source, one per error
    logic [15:0] code_w;
    always_comb begin
        unique case (ERR_SOURCE_I)
            SRC_UCODE_PAR: code_w = CODE_UCODE_PAR;
            SRC_EXTERNAL:  code_w = CODE_EXTERNAL;
            SRC_REDUNDANT: code_w = CODE_REDUNDANT;
            SRC_INTERNAL:  code_w = {PFX_INTERNAL, INTERNAL_DETAIL_I};
            SRC_TLB:       code_w = {PFX_TLB, tk_w, hl_w};
            SRC_CACHE:     code_w = {PFX_CACHE, rq_c, tk_w, hl_w};
            SRC_BUS:       code_w = {PFX_BUS, pp_w, to_w, rq_nc, as_w, hl_w};
            SRC_TIMER:     code_w = CODE_TIMER;
            default:       code_w = CODE_UNCLASS;
        endcase
    end

    // Two-flop synchronisers for bus-init, strap and enable pins
    // No reset here on purpose: the pins keep being sampled during reset,
    // so the strap value is already settled at the first edge after release.
    // Resetting these flops would hand the strap capture a forced zero.
    // Only the second flop of each stage is read by any logic.
    genvar g;
    generate
        for (g = 0; g < PIN_COUNT; g++) begin : g_pin_sync
            logic meta_q;
            logic sync_q;
            always_ff @(posedge CLOCK_I) begin
                meta_q <= pin_raw_w[g];
                sync_q <= meta_q;
            end
            assign pin_sync_q[g] = sync_q;
        end
    endgenerate

    // Power-on strap capture
    // The strap must be stable for at least two cycles before reset ends.
    // Changes of the strap pin after that are ignored until the next reset.
    // Strap latched once after reset release, like a power-on configuration
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            strap_seen_q <= 1'b0;
            strap_q      <= 1'b0;
        end else if (!strap_seen_q) begin
            strap_seen_q <= 1'b1;
            strap_q      <= pin_sync_q[PIN_STRAP];
        end
    end

    // Bus-init edge and exception gate
    // The previous-value flop resets to the idle level of the pin, so no
    // false edge appears after reset while the pin rests low.
    // A pin held high across reset gives no exception: only a fresh
    // assertion counts, which also stops a stuck pin from repeating pulses.
    wire logic bus_init_rise_w = pin_sync_q[PIN_BUS_INIT] && !bus_init_prev_q;
    wire logic take_exc_w      = bus_init_rise_w && strap_q && pin_sync_q[PIN_ENABLE];

    // Status capture
    // The code and the valid flag share one process so they can never
    // disagree; the exception pulse rides along as a plain registered copy.
    // Every output comes straight from a flop, so software and the checker
    // always see settled values after the edge.
    // Status capture; new error wins over a same-cycle clear
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            BANK_ERROR_STATUS_O <= CODE_NONE;
            ENTRY_VALID_FLAG_O  <= 1'b0;
            MC_EXCEPTION_O      <= 1'b0;
            bus_init_prev_q     <= 1'b0;
        end else begin
            bus_init_prev_q <= pin_sync_q[PIN_BUS_INIT];
            MC_EXCEPTION_O  <= take_exc_w;
            if (ERR_VALID_I) begin
                BANK_ERROR_STATUS_O <= code_w;
                ENTRY_VALID_FLAG_O  <= 1'b1;
            end else if (STATUS_CLEAR_I) begin
                BANK_ERROR_STATUS_O <= CODE_NONE;
                ENTRY_VALID_FLAG_O  <= 1'b0;
            end
        end
    end

endmodule : mcec_encoder
`default_nettype wire

// *** verification/mcec_encoder_chk.sv ***
// Port checker for the error code encoder
`timescale 1ns/10ps
`default_nettype none
module mcec_encoder_chk (
    input wire logic        CLOCK_I,
    input wire logic        RST_I,
    input wire logic        ERR_VALID_I,
    input wire logic [3:0]  ERR_SOURCE_I,
    input wire logic [1:0]  HIERARCHY_LEVEL_FIELD_I,
    input wire logic        TIMED_OUT_I,
    input wire logic [9:0]  INTERNAL_DETAIL_I,
    input wire logic [15:0] BANK_ERROR_STATUS_O,
    input wire logic        ENTRY_VALID_FLAG_O,
    input wire logic        MC_EXCEPTION_O
);
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);
    // Source seen only on a taken report; F marks an idle cycle
    wire logic [3:0]  es = ERR_VALID_I ? ERR_SOURCE_I : 4'hF;
    wire logic [15:0] cd = BANK_ERROR_STATUS_O;
    // Each report leaves its code one cycle later
    valid_set_a: assert property (ERR_VALID_I |=> ENTRY_VALID_FLAG_O)
        else $error("valid flag not set");
    idle_zero_a: assert property (!ENTRY_VALID_FLAG_O |-> cd == 16'h0000)
        else $error("code not zero while empty");
    unclass_a: assert property (es == 4'h0 |=> cd == 16'h0001)
        else $error("unclassified code wrong");
    simple_codes_a: assert property (es inside {4'h1, 4'h2, 4'h3} |=>
        cd == {12'h000, $past(es)} + 16'h0001) else $error("simple code wrong");
    internal_a: assert property (es == 4'h4 |=> cd == {6'h01, $past(INTERNAL_DETAIL_I)})
        else $error("internal code wrong");
    tlb_form_a: assert property (es == 4'h5 |=> cd[15:4] == 12'h001 && cd[3:2] != 2'h3
        && cd[1:0] == $past(HIERARCHY_LEVEL_FIELD_I)) else $error("tlb code wrong");
    cache_form_a: assert property (es == 4'h6 |=> cd[15:8] == 8'h01 && cd[7:4] <= 4'h8)
        else $error("cache code wrong");
    bus_form_a: assert property (es == 4'h7 |=> cd[15:11] == 5'h01 && cd[7:4] < 4'h7
        && cd[3:2] != 2'h1 && cd[8] == $past(TIMED_OUT_I)) else $error("bus code wrong");
    timer_a: assert property (es == 4'h8 |=> cd == 16'h0400)
        else $error("timer code wrong");
    exc_pulse_a: assert property (MC_EXCEPTION_O |=> !MC_EXCEPTION_O)
        else $error("exception pulse too long");
    cover property (es == 4'h7);
    cover property (MC_EXCEPTION_O);
    cover property (ENTRY_VALID_FLAG_O ##1 !ENTRY_VALID_FLAG_O);
endmodule : mcec_encoder_chk
bind mcec_encoder mcec_encoder_chk u_chk (.CLOCK_I, .RST_I, .ERR_VALID_I, .ERR_SOURCE_I,
    .HIERARCHY_LEVEL_FIELD_I, .TIMED_OUT_I, .INTERNAL_DETAIL_I, .BANK_ERROR_STATUS_O,
    .ENTRY_VALID_FLAG_O, .MC_EXCEPTION_O);
`default_nettype wire

// *** verification/mcec_encoder_test.sv ***
// Self-checking bench for the error code encoder
`timescale 1ns/10ps
`default_nettype none
module mcec_encoder_test;
    logic clk = 0, rst = 1, ev = 0, tmo = 0, clr = 0, bi = 0, en = 1, strap = 1;
    logic [3:0] src = 0, rq = 0;
    logic [1:0] tk = 0, hl = 0, pp = 0, sp = 0;
    logic [9:0] det = 0;
    logic [15:0] code;
    logic vld, exc;
    int n_fail = 0, checks = 0;
    always #5 clk = ~clk;
    mcec_encoder dut (.CLOCK_I(clk), .RST_I(rst), .ERR_VALID_I(ev), .ERR_SOURCE_I(src),
        .TRANSACTION_KIND_FIELD_I(tk), .HIERARCHY_LEVEL_FIELD_I(hl), .REQUEST_KIND_FIELD_I(rq),
        .PARTICIPATION_FIELD_I(pp), .TIMED_OUT_I(tmo), .ACCESS_SPACE_FIELD_I(sp),
        .INTERNAL_DETAIL_I(det), .STATUS_CLEAR_I(clr), .BUS_INIT_SIGNAL_I(bi),
        .OBSERVE_STRAP_I(strap), .MACHINE_CHECK_ENABLE_BIT_I(en), .BANK_ERROR_STATUS_O(code),
        .ENTRY_VALID_FLAG_O(vld), .MC_EXCEPTION_O(exc));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    // One report per cycle; strobe stays up so calls may run back to back
    task automatic send(input logic [3:0] s, input logic [15:0] exp);
        src = s;
        ev = 1;
        @(negedge clk);
        chk(code, exp);
        chk({15'h0, vld}, 16'h1);
    endtask : send
    // Bounded wait for the exception pulse; a miss when one is due ends the run
    task automatic bus_init(input logic want);
        bi = 1;
        for (int k = 0; k < 8 && exc !== 1'b1; k++) @(negedge clk);
        bi = 0;
        chk({15'h0, exc}, {15'h0, want});
        if (want && exc !== 1'b1) report_and_stop;
        repeat (6) @(negedge clk);
    endtask : bus_init
    initial begin
        repeat (5) @(negedge clk);
        rst = 0;
        chk({vld, code}, 17'h0);
        send(4'h0, 16'h0001);
        send(4'h9, 16'h0001);
        for (int i = 1; i < 4; i++) send(i[3:0], 16'(i + 1));
        det = 10'h3A5;
        send(4'h4, 16'h07A5);
        tk = 1;
        hl = 2;
        send(4'h5, 16'h0016);
        tk = 3;
        hl = 3;
        send(4'h5, 16'h001B);
        tk = 0;
        for (int r = 0; r < 9; r++) begin
            rq = r[3:0];
            hl = r[1:0];
            send(4'h6, {8'h01, rq, 2'h0, hl});
        end
        {pp, tmo, rq, sp, hl} = {2'h2, 1'b1, 4'h3, 2'h2, 2'h1};
        send(4'h7, 16'h0D39);
        {pp, tmo, rq, sp, hl} = {2'h1, 1'b0, 4'h7, 2'h1, 2'h0};
        send(4'h7, 16'h0A0C);
        clr = 1;
        send(4'h8, 16'h0400);
        clr = 0;
        ev = 0;
        repeat (3) @(negedge clk);
        chk(code, 16'h0400);
        clr = 1;
        @(negedge clk);
        clr = 0;
        chk({vld, code}, 17'h0);
        bus_init(1'b1);
        en = 0;
        bus_init(1'b0);
        en = 1;
        strap = 0;
        rst = 1;
        repeat (5) @(negedge clk);
        rst = 0;
        chk({vld, code}, 17'h0);
        bus_init(1'b0);
        report_and_stop;
    end
endmodule : mcec_encoder_test
`default_nettype wire
